// File: common/crxbf_pkg.sv
// crxbf_pkg: register map, reset values and widths of the receive buffer flag bank
// assumes APB with 32-bit data, one aligned word per register
package crxbf_pkg;
  localparam int          NUM_BUFFERS   = 32;
  localparam int          REG_WIDTH     = 16;
  localparam int          ADDR_WIDTH    = 5;
  localparam int          IDX_WIDTH     = 5;
  localparam logic [4:0]  OFF_FULL_LOW  = 5'h00;
  localparam logic [4:0]  OFF_FULL_HIGH = 5'h04;
  localparam logic [4:0]  OFF_OVF_LOW   = 5'h08;
  localparam logic [4:0]  OFF_OVF_HIGH  = 5'h0c;
  localparam logic [4:0]  OFF_IRQ_STAT  = 5'h10;
  localparam logic [4:0]  OFF_IRQ_MASK  = 5'h14;
  localparam int          IRQ_BITS      = 2;
  localparam int          IRQ_FILL_BIT  = 0;
  localparam int          IRQ_OVF_BIT   = 1;
  localparam logic [15:0] FLAGS_RESET   = 16'h0000;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
endpackage : crxbf_pkg

// File: common/crxbf_wr_if.sv
// crxbf_wr_if: software write-clear request carried from the bus slave to a flag half
// assumes one clock domain; strobe is a single-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface crxbf_wr_if;
  logic        clr_stb;
  logic [15:0] wdata;
  logic [15:0] flags;
  modport master (output clr_stb, output wdata, input flags);
  modport slave  (input clr_stb, input wdata, output flags);
endinterface : crxbf_wr_if
`default_nettype wire

// File: rtl/crxbf_flag_half.sv
// crxbf_flag_half: sixteen write-zero-to-clear flags, hardware set wins over clear
// assumes set pulses and clear strobe are synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module crxbf_flag_half #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // hardware set, one bit per buffer
  input  wire logic [WIDTH-1:0] set_i,
  // software side
  crxbf_wr_if.slave             sw
);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sw.flags <= crxbf_pkg::FLAGS_RESET;
    end else if (sw.clr_stb) begin
      // zero clears, one keeps; a set in the same cycle survives
      sw.flags <= (sw.flags & sw.wdata) | set_i;
    end else begin
      sw.flags <= sw.flags | set_i;
    end
  end

  AST_SET_STICKS: assert property (@(posedge mclk_i) disable iff (reset_i)
      (set_i != '0) |=> ((sw.flags & $past(set_i)) == $past(set_i)))
    else $error("hardware set lost");
  AST_ONE_KEEPS: assert property (@(posedge mclk_i) disable iff (reset_i)
      sw.clr_stb |=> ((sw.flags & $past(sw.flags) & $past(sw.wdata))
                      == ($past(sw.flags) & $past(sw.wdata))))
    else $error("writing one changed a flag");
endmodule // crxbf_flag_half
`default_nettype wire

// File: rtl/crxbf_top.sv
// crxbf_top: full and overflow flag bank for 32 receive buffers, with APB access
// assumes the receive engine drives a one-cycle store pulse with a buffer index
//
// Behaviour
// - store into buffer n sets full flag
// - zero clears a flag, one leaves it
// - store into full buffer sets overflow flag
// - overflow flags split like full flags
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module crxbf_top #(
  parameter int NUM_BUFFERS = crxbf_pkg::NUM_BUFFERS
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [4:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // receive engine
  input  wire logic        store_req_i,
  input  wire logic [4:0]  store_idx_i,
  output logic             store_grant_o,
  // interrupt
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  crxbf_wr_if full_lo ();
  crxbf_wr_if full_hi ();
  crxbf_wr_if ovf_lo ();
  crxbf_wr_if ovf_hi ();

  logic [31:0] full_all;
  logic [31:0] ovf_all;
  logic [31:0] sel_onehot;
  logic        target_full;
  logic        accepted;
  logic        refused;
  logic [31:0] fill_set;
  logic [31:0] ovf_set;
  logic        wr_access;
  logic        addr_ok;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;

  // upper half holds buffers 16..31 in ascending order
  assign full_all = {full_hi.flags, full_lo.flags};
  assign ovf_all  = {ovf_hi.flags, ovf_lo.flags};

  ////////////////////////////////////////////////////////////////////////////
  // receive engine: grant only when the target buffer is empty
  assign sel_onehot    = 32'h00000001 << store_idx_i;
  assign target_full   = full_all[store_idx_i];
  assign accepted      = store_req_i && !target_full;
  assign refused       = store_req_i && target_full;
  // engine must not write the buffer when grant is low, so old contents stay
  assign store_grant_o = accepted;
  assign fill_set      = accepted ? sel_onehot : 32'h00000000;
  assign ovf_set       = refused ? sel_onehot : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states
  assign wr_access = psel_i && penable_i && pwrite_i;
  assign pready_o  = 1'b1;
  assign addr_ok   = (paddr_i == crxbf_pkg::OFF_FULL_LOW) || (paddr_i == crxbf_pkg::OFF_FULL_HIGH)
                  || (paddr_i == crxbf_pkg::OFF_OVF_LOW)  || (paddr_i == crxbf_pkg::OFF_OVF_HIGH)
                  || (paddr_i == crxbf_pkg::OFF_IRQ_STAT) || (paddr_i == crxbf_pkg::OFF_IRQ_MASK);
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  // software clears only by a zero write
  assign full_lo.clr_stb = wr_access && (paddr_i == crxbf_pkg::OFF_FULL_LOW);
  assign full_hi.clr_stb = wr_access && (paddr_i == crxbf_pkg::OFF_FULL_HIGH);
  assign ovf_lo.clr_stb  = wr_access && (paddr_i == crxbf_pkg::OFF_OVF_LOW);
  assign ovf_hi.clr_stb  = wr_access && (paddr_i == crxbf_pkg::OFF_OVF_HIGH);
  assign full_lo.wdata   = pwdata_i[15:0];
  assign full_hi.wdata   = pwdata_i[15:0];
  assign ovf_lo.wdata    = pwdata_i[15:0];
  assign ovf_hi.wdata    = pwdata_i[15:0];

  crxbf_flag_half #(.WIDTH(16)) u_full_lo (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .set_i   (fill_set[15:0]),
    .sw      (full_lo)
  );
  crxbf_flag_half #(.WIDTH(16)) u_full_hi (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .set_i   (fill_set[31:16]),
    .sw      (full_hi)
  );
  crxbf_flag_half #(.WIDTH(16)) u_ovf_lo (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .set_i   (ovf_set[15:0]),
    .sw      (ovf_lo)
  );
  crxbf_flag_half #(.WIDTH(16)) u_ovf_hi (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .set_i   (ovf_set[31:16]),
    .sw      (ovf_hi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: bit0 buffer filled, bit1 overflow; write one clears, set wins
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat <= crxbf_pkg::IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~((wr_access && paddr_i == crxbf_pkg::OFF_IRQ_STAT)
                                ? pwdata_i[1:0] : 2'h0))
                | {refused, accepted};
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask <= crxbf_pkg::IRQ_RESET;
    end else if (wr_access && paddr_i == crxbf_pkg::OFF_IRQ_MASK) begin
      irq_mask <= pwdata_i[1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // read data registered at the setup cycle so it is stable in the access phase
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        crxbf_pkg::OFF_FULL_LOW:  prdata_o <= {16'h0000, full_lo.flags};
        crxbf_pkg::OFF_FULL_HIGH: prdata_o <= {16'h0000, full_hi.flags};
        crxbf_pkg::OFF_OVF_LOW:   prdata_o <= {16'h0000, ovf_lo.flags};
        crxbf_pkg::OFF_OVF_HIGH:  prdata_o <= {16'h0000, ovf_hi.flags};
        crxbf_pkg::OFF_IRQ_STAT:  prdata_o <= {30'h0, irq_stat};
        crxbf_pkg::OFF_IRQ_MASK:  prdata_o <= {30'h0, irq_mask};
        default:                  prdata_o <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_FILL_SETS: assert property (@(posedge mclk_i) disable iff (reset_i)
      accepted |=> full_all[$past(store_idx_i)])
    else $error("full flag not set after store");
  AST_HIGH_MAP: assert property (@(posedge mclk_i) disable iff (reset_i)
      (accepted && store_idx_i[4]) |=> full_hi.flags[$past(store_idx_i[3:0])])
    else $error("upper buffer not in second full register");
  AST_OVF_SETS: assert property (@(posedge mclk_i) disable iff (reset_i)
      (store_req_i && full_all[store_idx_i]) |=> ovf_all[$past(store_idx_i)])
    else $error("overflow flag not set");
  AST_OVF_HIGH: assert property (@(posedge mclk_i) disable iff (reset_i)
      (refused && store_idx_i[4]) |=> ovf_hi.flags[$past(store_idx_i[3:0])])
    else $error("upper overflow misplaced");
  AST_OVF_HOLDS: assert property (@(posedge mclk_i) disable iff (reset_i)
      (ovf_all[0] && !ovf_lo.clr_stb) |=> ovf_all[0])
    else $error("overflow flag dropped without clear");
  AST_FULL_CLEAR: assert property (@(posedge mclk_i) disable iff (reset_i)
      (full_lo.clr_stb && !pwdata_i[0] && !fill_set[0]) |=> !full_all[0])
    else $error("zero write did not clear full flag");
  // looks at the halves directly so a wrong index split cannot hide behind full_all
  AST_NO_GRANT_FULL: assert property (@(posedge mclk_i) disable iff (reset_i)
      (store_req_i && (store_idx_i[4] ? full_hi.flags[store_idx_i[3:0]]
                                      : full_lo.flags[store_idx_i[3:0]])) |-> !store_grant_o)
    else $error("store granted into full buffer");
  // a mask write in the same cycle may legally close the interrupt
  AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (reset_i)
      (refused && irq_mask[1] && !(wr_access && paddr_i == crxbf_pkg::OFF_IRQ_MASK)) |=> irq_o)
    else $error("interrupt missing after overflow");
endmodule // crxbf_top
`default_nettype wire

// File: testbench/crxbf_engine_model.sv
// crxbf_engine_model: receive engine offering one message per go pulse
// assumes go_i and idx_i change just after mclk_i rises
`timescale 1ns/1ps
`default_nettype none
module crxbf_engine_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  // command from bench
  input  wire logic       go_i,
  input  wire logic [4:0] idx_i,
  // store port
  input  wire logic       store_grant_i,
  output logic            store_req_o,
  output logic      [4:0] store_idx_o,
  output var int          stored_o
);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      store_req_o <= 1'b0;
      store_idx_o <= 5'h00;
      stored_o    <= 0;
    end else begin
      store_req_o <= go_i;
      // idle index keeps moving so a stale value never looks valid
      store_idx_o <= go_i ? idx_i : ~store_idx_o;
      if (store_req_o && store_grant_i) begin
        stored_o <= stored_o + 1;
      end
    end
  end
endmodule // crxbf_engine_model
`default_nettype wire

// File: testbench/crxbf_top_tb.sv
// crxbf_top_tb: random stores and software clears against a bit-vector model
// assumes the flag bank answers APB with no fixed wait count
`timescale 1ns/1ps
`default_nettype none
module crxbf_top_tb;
  logic        mclk_i, reset_i, psel, penable, pwrite, go, grant, req, pready, pslverr, irq;
  logic [4:0]  paddr, idx, sidx;
  logic [31:0] pwdata, prdata, rd, w, m_full, m_ovf;
  logic [1:0]  m_stat;
  logic        err;
  logic [4:0]  seq [5] = '{5'h1f, 5'h1f, 5'h10, 5'h00, 5'h00};
  int          n_errors, checked, m_stored, stored;
  int          cycles = 0;

  crxbf_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .store_req_i(req), .store_idx_i(sidx),
    .store_grant_o(grant), .irq_o(irq));
  crxbf_engine_model eng_u (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go), .idx_i(idx),
    .store_grant_i(grant), .store_req_o(req), .store_idx_o(sidx), .stored_o(stored));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_cmp(input logic [4:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rd);
  endtask

  task automatic flags();
    rd_cmp(crxbf_pkg::OFF_FULL_LOW, {16'h0, m_full[15:0]}, "full_low");
    rd_cmp(crxbf_pkg::OFF_FULL_HIGH, {16'h0, m_full[31:16]}, "full_high");
    rd_cmp(crxbf_pkg::OFF_OVF_LOW, {16'h0, m_ovf[15:0]}, "ovf_low");
    rd_cmp(crxbf_pkg::OFF_OVF_HIGH, {16'h0, m_ovf[31:16]}, "ovf_high");
    rd_cmp(crxbf_pkg::OFF_IRQ_STAT, {30'h0, m_stat}, "irq_stat");
    cmp("stored", m_stored, stored);
  endtask

  task automatic store(input logic [4:0] n);
    @(posedge mclk_i);
    go  <= 1'b1;
    idx <= n;
    @(posedge mclk_i);
    go <= 1'b0;
    #1 cmp("grant", {31'h0, ~m_full[n]}, {31'h0, grant});
    m_ovf[n] = m_ovf[n] | m_full[n];
    m_stat = m_stat | (m_full[n] ? 2'h2 : 2'h1);
    m_stored += int'(!m_full[n]);
    m_full[n] = 1'b1;
    @(posedge mclk_i);
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, go} = 4'h0;
    {paddr, idx, pwdata} = '0;
    {m_full, m_ovf, m_stat} = '0;
    {n_errors, checked, m_stored} = '0;
    reset_i = 1'b1;
    void'($urandom(32'h22059c7c));
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    flags();
    rd_cmp(crxbf_pkg::OFF_IRQ_MASK, 32'h0, "irq_mask");
    foreach (seq[i]) store(seq[i]);
    repeat (40) store(5'($urandom_range(0, 31)));
    flags();
    for (int r = 0; r < 4; r++) begin
      w = $urandom;
      apb(1'b1, 5'(r * 4), w);
      if (r < 2) m_full[r*16 +: 16] &= w[15:0];
      else m_ovf[(r-2)*16 +: 16] &= w[15:0];
    end
    flags();
    repeat (12) store(5'($urandom_range(0, 31)));
    apb(1'b1, crxbf_pkg::OFF_IRQ_MASK, 32'h0);
    #1 cmp("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, crxbf_pkg::OFF_IRQ_MASK, 32'h3);
    #1 cmp("irq_open", {31'h0, |m_stat}, {31'h0, irq});
    apb(1'b1, crxbf_pkg::OFF_IRQ_STAT, 32'h1);
    m_stat[0] = 1'b0;
    #1 cmp("irq_half", {31'h0, m_stat[1]}, {31'h0, irq});
    apb(1'b1, crxbf_pkg::OFF_IRQ_STAT, 32'h2);
    m_stat = 2'h0;
    #1 cmp("irq_clear", 32'h0, {31'h0, irq});
    // unmapped place: refused, reads zero, write has no effect
    apb(1'b1, 5'h18, 32'h0);
    cmp("slverr_wr", 32'h1, {31'h0, err});
    rd_cmp(5'h18, 32'h0, "unmapped");
    cmp("slverr_rd", 32'h1, {31'h0, err});
    flags();
    report_and_stop();
  end
endmodule // crxbf_top_tb
`default_nettype wire
